// >>> hw/i2c_cfg_pkg.sv
/*
 * Shared constants and state types for the configuration port link:
 * target address, timing counts, register layout and state encodings.
 * Assumes a 100 MHz system clock on both ends of the link.
 */
package i2c_cfg_pkg;

    localparam int CLK_PERIOD_NS = 10;

    // Target address: six fixed bits, low bit from the select pin
    localparam logic [5:0] ADDR_FIXED_HI = 6'h38;
    localparam logic [6:0] ADDR_NO_PIN = 7'h70;

    // Configuration space
    localparam int RAM_DEPTH = 256;
    localparam logic [7:0] LOWV_REG = 8'h1B;
    localparam int LOWV_BIT = 7;

    // Nine bit slots per byte, the last one is the acknowledge
    localparam logic [3:0] BIT_LAST_DATA = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;

    // Data line timeout
    localparam int TIMEOUT_MS = 25;
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (1000000 / CLK_PERIOD_NS);

    // Spike suppression on the link inputs
    localparam int SPIKE_NS = 50;
    localparam int SPIKE_CYCLES = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Bus rates, as full bit periods; master works in quarter periods
    localparam int STD_PERIOD_NS = 10000;
    localparam int FAST_PERIOD_NS = 2500;
    localparam int QTR_STD = (STD_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QTR_FAST = (FAST_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_REG   = 3'h2,
        ST_WDATA = 3'h3,
        ST_RDATA = 3'h4
    } target_state_e;

    typedef enum logic [1:0] {
        M_IDLE  = 2'h0,
        M_START = 2'h1,
        M_BYTE  = 2'h2,
        M_STOP  = 2'h3
    } master_state_e;

    typedef enum logic [2:0] {
        K_ADDRW = 3'h0,
        K_REG   = 3'h1,
        K_WDATA = 3'h2,
        K_ADDRR = 3'h3,
        K_RDATA = 3'h4
    } byte_kind_e;

endpackage

// >>> hw/i2c_link_if.sv
/*
 * Two-wire link between the configuration master and the target.
 * Both lines are open drain with pull-ups; the wire levels are resolved
 * here from each party's output and output enable.
 */
`timescale 1ns/100ps
interface i2c_link_if;
    logic scl_out;
    logic scl_oe;
    logic m_sda_out;
    logic m_sda_oe;
    logic t_sda_out;
    logic t_sda_oe;
    logic scl;
    logic sda;

    // Pull-up wins unless someone drives low
    assign scl = ~(scl_oe & ~scl_out);
    assign sda = ~((m_sda_oe & ~m_sda_out) | (t_sda_oe & ~t_sda_out));

    modport target (
        input scl,
        input sda,
        output t_sda_out,
        output t_sda_oe
    );

    modport master (
        input sda,
        output scl_out,
        output scl_oe,
        output m_sda_out,
        output m_sda_oe
    );
endinterface

// >>> hw/i2c_config_target.sv
/*
 * Target end of the configuration port: decodes the two-wire link and
 * gives the far master byte access to a 256-entry configuration RAM.
 * Assumes the master generates the link clock and that scl and sda are
 * asynchronous to sys_clk; both are synchronised and filtered here.
 */
// Operation
// - Target only, answers a 7-bit address.
// - Works at 100 and 400 kbps.
// - Address is fixed bits plus select pin.
// - No-pin variant answers at 1110000.
// - Bytes are eight bits, MSB first.
// - Write: address, register byte, data byte.
// - Burst writes advance the register pointer.
// - Read after pointer-setting write returns register.
// - Burst reads return successive registers.
// - Data line timeout releases stalled transfers.
// - Host sets reg 27 bit 7 below 2.5 V.
`timescale 1ns/100ps
module i2c_config_target #(
    parameter bit HAS_ADDR_SEL = 1'b1,
    parameter int unsigned TIMEOUT_CYCLES = i2c_cfg_pkg::TIMEOUT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    i2c_link_if.target link,
    input wire logic addr_sel,
    input wire logic [7:0] user_addr,
    output logic [7:0] user_data,
    output logic wr_strobe,
    output logic [7:0] wr_addr,
    output logic [7:0] wr_data,
    output logic low_volt_mode
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and spike filters

    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] filt;
    logic [1:0] filt_prev;
    logic [1:0] sel_sync;
    wire logic [1:0] raw_in = {link.sda, link.scl};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_line
            logic [3:0] stable_cnt;
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    sync_a[g] <= 1'b1;
                    sync_b[g] <= 1'b1;
                    filt[g] <= 1'b1;
                    filt_prev[g] <= 1'b1;
                    stable_cnt <= 4'h0;
                end else begin
                    sync_a[g] <= raw_in[g];
                    sync_b[g] <= sync_a[g];
                    filt_prev[g] <= filt[g];
                    // Pulses shorter than the spike window never reach the decoder
                    if (sync_b[g] == filt[g]) begin
                        stable_cnt <= 4'h0;
                    end else if (stable_cnt == 4'(i2c_cfg_pkg::SPIKE_CYCLES - 1)) begin
                        stable_cnt <= 4'h0;
                        filt[g] <= sync_b[g];
                    end else begin
                        stable_cnt <= stable_cnt + 4'h1;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sel_sync <= 2'h0;
        end else begin
            sel_sync <= {sel_sync[0], addr_sel};
        end
    end

    wire logic scl_now = filt[0];
    wire logic sda_now = filt[1];
    wire logic scl_rise = scl_now & ~filt_prev[0];
    wire logic scl_fall = ~scl_now & filt_prev[0];
    wire logic start_det = scl_now & filt_prev[0] & filt_prev[1] & ~sda_now;
    wire logic stop_det = scl_now & filt_prev[0] & ~filt_prev[1] & sda_now;

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    i2c_cfg_pkg::target_state_e state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic drive_low;
    logic nack;
    logic [31:0] tmo_cnt;
    logic [7:0] mem [i2c_cfg_pkg::RAM_DEPTH];

    wire logic [6:0] own_addr = HAS_ADDR_SEL ? {i2c_cfg_pkg::ADDR_FIXED_HI, sel_sync[1]}
                                             : i2c_cfg_pkg::ADDR_NO_PIN;
    wire logic addr_hit = (shift[7:1] == own_addr);
    wire logic dir_read = shift[0];
    wire logic active = (state != i2c_cfg_pkg::ST_IDLE);
    wire logic ack_begin = active && scl_fall && (bit_cnt == i2c_cfg_pkg::BIT_LAST_DATA);
    wire logic ack_end = active && scl_fall && (bit_cnt == i2c_cfg_pkg::BIT_ACK);
    wire logic store = ack_begin && (state == i2c_cfg_pkg::ST_WDATA);
    wire logic load_next = ack_end
        && (((state == i2c_cfg_pkg::ST_ADDR) && addr_hit && dir_read)
        || ((state == i2c_cfg_pkg::ST_RDATA) && !nack));
    wire logic [7:0] rd_byte = mem[ptr];
    // Counts only while a transfer is open and the clock line sits still
    wire logic timed_out = active && (tmo_cnt == 32'(TIMEOUT_CYCLES - 1));

    always_ff @(posedge sys_clk) begin
        if (sys_rst || !active || scl_rise || scl_fall) begin
            tmo_cnt <= 32'h0;
        end else if (!timed_out) begin
            tmo_cnt <= tmo_cnt + 32'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= i2c_cfg_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            tx <= 8'h00;
            ptr <= 8'h00;
            drive_low <= 1'b0;
            nack <= 1'b1;
        end else if (timed_out) begin
            // Let go of the data line so a stuck master can recover
            state <= i2c_cfg_pkg::ST_IDLE;
            drive_low <= 1'b0;
        end else if (start_det) begin
            // Repeated start lands here too, keeping the pointer
            state <= i2c_cfg_pkg::ST_ADDR;
            // The scl fall that closes a start is no bit; it wraps this to zero
            bit_cnt <= 4'hF;
            drive_low <= 1'b0;
        end else if (stop_det) begin
            state <= i2c_cfg_pkg::ST_IDLE;
            drive_low <= 1'b0;
        end else if (active && scl_rise) begin
            if (bit_cnt < i2c_cfg_pkg::BIT_ACK) begin
                shift <= {shift[6:0], sda_now};
            end else begin
                nack <= sda_now;
            end
        end else if (ack_begin) begin
            bit_cnt <= i2c_cfg_pkg::BIT_ACK;
            unique case (state)
                i2c_cfg_pkg::ST_ADDR: begin
                    drive_low <= addr_hit;
                end
                i2c_cfg_pkg::ST_REG: begin
                    ptr <= shift;
                    drive_low <= 1'b1;
                end
                i2c_cfg_pkg::ST_WDATA: begin
                    ptr <= ptr + 8'h01;
                    drive_low <= 1'b1;
                end
                i2c_cfg_pkg::ST_RDATA: begin
                    drive_low <= 1'b0;
                end
            endcase
        end else if (ack_end) begin
            bit_cnt <= 4'h0;
            drive_low <= 1'b0;
            if (load_next) begin
                state <= i2c_cfg_pkg::ST_RDATA;
                tx <= rd_byte;
                ptr <= ptr + 8'h01;
                drive_low <= ~rd_byte[7];
            end else begin
                unique case (state)
                    i2c_cfg_pkg::ST_ADDR: begin
                        state <= (addr_hit && !dir_read) ? i2c_cfg_pkg::ST_REG
                                                         : i2c_cfg_pkg::ST_IDLE;
                    end
                    i2c_cfg_pkg::ST_REG: begin
                        state <= i2c_cfg_pkg::ST_WDATA;
                    end
                    i2c_cfg_pkg::ST_WDATA: begin
                        state <= i2c_cfg_pkg::ST_WDATA;
                    end
                    i2c_cfg_pkg::ST_RDATA: begin
                        // Master declined more data; wait for stop
                        state <= i2c_cfg_pkg::ST_IDLE;
                    end
                endcase
            end
        end else if (active && scl_fall) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (state == i2c_cfg_pkg::ST_RDATA) begin
                drive_low <= ~tx[6];
                tx <= {tx[6:0], 1'b0};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration RAM and user side

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < i2c_cfg_pkg::RAM_DEPTH; i++) begin
                mem[i] <= 8'h00;
            end
            wr_strobe <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= 8'h00;
            low_volt_mode <= 1'b0;
            user_data <= 8'h00;
        end else begin
            wr_strobe <= store;
            if (store) begin
                mem[ptr] <= shift;
                wr_addr <= ptr;
                wr_data <= shift;
                if (ptr == i2c_cfg_pkg::LOWV_REG) begin
                    low_volt_mode <= shift[i2c_cfg_pkg::LOWV_BIT];
                end
            end
            user_data <= mem[user_addr];
        end
    end

    logic sda_out;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // Open drain: only ever pull low
    assign link.t_sda_out = sda_out;
    assign link.t_sda_oe = drive_low;

endmodule

// >>> hw/i2c_config_master.sv
/*
 * Master end of the configuration link: runs register write and read
 * bursts on the two-wire link, making the link clock by division.
 * Assumes the target never stretches the clock; sda is synchronised.
 */
`timescale 1ns/100ps
module i2c_config_master (
    input wire logic sys_clk,
    input wire logic sys_rst,
    i2c_link_if.master link,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic fast_mode,
    input wire logic [6:0] cmd_target,
    input wire logic [7:0] cmd_reg,
    input wire logic [7:0] cmd_count,
    input wire logic [7:0] wr_data,
    output logic busy,
    output logic byte_done,
    output logic [7:0] rd_data,
    output logic done,
    output logic nack_err
);

    i2c_cfg_pkg::master_state_e mstate;
    i2c_cfg_pkg::byte_kind_e kind;
    logic [1:0] sda_sync;
    logic [7:0] qcnt;
    logic [7:0] qtr_lim;
    logic [1:0] phase;
    logic [3:0] bitn;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] remain;
    logic rw_write;
    logic [6:0] tgt;
    logic [7:0] regv;
    logic got_nack;
    logic scl_oe;
    logic sda_oe;
    logic pin_out;

    wire logic tick = (mstate != i2c_cfg_pkg::M_IDLE) && (qcnt == qtr_lim);
    wire logic sending = (kind != i2c_cfg_pkg::K_RDATA);
    wire logic more = (remain != 8'h01);
    wire logic [7:0] src = (kind == i2c_cfg_pkg::K_ADDRW) ? {tgt, 1'b0}
                         : (kind == i2c_cfg_pkg::K_REG) ? regv
                         : (kind == i2c_cfg_pkg::K_ADDRR) ? {tgt, 1'b1}
                         : wr_data;
    wire logic out_bit = (bitn == 4'h0) ? src[7] : tx[3'h7 - bitn[2:0]];
    wire logic accept = (mstate == i2c_cfg_pkg::M_IDLE) && cmd_valid && !busy;

    ////////////////////////////////////////////////////////////////////////////
    // Quarter-period timebase

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sda_sync <= 2'h3;
            qcnt <= 8'h00;
        end else begin
            sda_sync <= {sda_sync[0], link.sda};
            qcnt <= (tick || mstate == i2c_cfg_pkg::M_IDLE) ? 8'h00 : qcnt + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transfer sequencing

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mstate <= i2c_cfg_pkg::M_IDLE;
            kind <= i2c_cfg_pkg::K_ADDRW;
            qtr_lim <= 8'h00;
            phase <= 2'h0;
            bitn <= 4'h0;
            tx <= 8'h00;
            rx <= 8'h00;
            remain <= 8'h00;
            rw_write <= 1'b0;
            tgt <= 7'h00;
            regv <= 8'h00;
            got_nack <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            busy <= 1'b0;
            byte_done <= 1'b0;
            rd_data <= 8'h00;
            done <= 1'b0;
            nack_err <= 1'b0;
        end else begin
            byte_done <= 1'b0;
            done <= 1'b0;
            if (accept) begin
                // Either rate may be chosen per command
                qtr_lim <= fast_mode ? 8'(i2c_cfg_pkg::QTR_FAST - 1)
                                     : 8'(i2c_cfg_pkg::QTR_STD - 1);
                mstate <= i2c_cfg_pkg::M_START;
                kind <= i2c_cfg_pkg::K_ADDRW;
                phase <= 2'h0;
                rw_write <= cmd_write;
                tgt <= cmd_target;
                regv <= cmd_reg;
                remain <= cmd_count;
                busy <= 1'b1;
                nack_err <= 1'b0;
            end else if (tick) begin
                phase <= phase + 2'h1;
                unique case (mstate)
                    i2c_cfg_pkg::M_START: begin
                        unique case (phase)
                            2'h0: sda_oe <= 1'b0;
                            2'h1: scl_oe <= 1'b0;
                            2'h2: sda_oe <= 1'b1;
                            2'h3: begin
                                scl_oe <= 1'b1;
                                bitn <= 4'h0;
                                mstate <= i2c_cfg_pkg::M_BYTE;
                            end
                        endcase
                    end
                    i2c_cfg_pkg::M_BYTE: begin
                        unique case (phase)
                            2'h0: begin
                                if (bitn == 4'h0) begin
                                    tx <= src;
                                end
                                if (bitn < i2c_cfg_pkg::BIT_ACK) begin
                                    sda_oe <= sending & ~out_bit;
                                end else begin
                                    // Acknowledge read bytes except the last
                                    sda_oe <= ~sending & more;
                                end
                            end
                            2'h1: scl_oe <= 1'b0;
                            2'h2: begin
                                if (bitn < i2c_cfg_pkg::BIT_ACK) begin
                                    rx <= {rx[6:0], sda_sync[1]};
                                end else begin
                                    got_nack <= sda_sync[1];
                                end
                            end
                            2'h3: begin
                                scl_oe <= 1'b1;
                                bitn <= (bitn == i2c_cfg_pkg::BIT_ACK) ? 4'h0 : bitn + 4'h1;
                                if (bitn == i2c_cfg_pkg::BIT_ACK) begin
                                    if (sending && got_nack) begin
                                        nack_err <= 1'b1;
                                        mstate <= i2c_cfg_pkg::M_STOP;
                                    end else begin
                                        unique case (kind)
                                            i2c_cfg_pkg::K_ADDRW: kind <= i2c_cfg_pkg::K_REG;
                                            i2c_cfg_pkg::K_REG: begin
                                                if (rw_write) begin
                                                    kind <= i2c_cfg_pkg::K_WDATA;
                                                end else begin
                                                    kind <= i2c_cfg_pkg::K_ADDRR;
                                                    mstate <= i2c_cfg_pkg::M_START;
                                                end
                                            end
                                            i2c_cfg_pkg::K_ADDRR: kind <= i2c_cfg_pkg::K_RDATA;
                                            i2c_cfg_pkg::K_WDATA,
                                            i2c_cfg_pkg::K_RDATA: begin
                                                byte_done <= 1'b1;
                                                remain <= remain - 8'h01;
                                                if (kind == i2c_cfg_pkg::K_RDATA) begin
                                                    rd_data <= rx;
                                                end
                                                if (!more) begin
                                                    mstate <= i2c_cfg_pkg::M_STOP;
                                                end
                                            end
                                        endcase
                                    end
                                end
                            end
                        endcase
                    end
                    i2c_cfg_pkg::M_STOP: begin
                        unique case (phase)
                            2'h0: sda_oe <= 1'b1;
                            2'h1: scl_oe <= 1'b0;
                            2'h2: sda_oe <= 1'b0;
                            2'h3: begin
                                mstate <= i2c_cfg_pkg::M_IDLE;
                                busy <= 1'b0;
                                done <= 1'b1;
                            end
                        endcase
                    end
                    default: mstate <= i2c_cfg_pkg::M_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_out <= 1'b0;
        end else begin
            pin_out <= 1'b0;
        end
    end

    assign link.scl_out = pin_out;
    assign link.scl_oe = scl_oe;
    assign link.m_sda_out = pin_out;
    assign link.m_sda_oe = sda_oe;

endmodule

// >>> testbench/i2c_link_monitor.sv
/* Link monitor: timing and ownership of the two open-drain lines.
   Assumes both ends run on sys_clk with a synchronous reset. */
`timescale 1ns/100ps
module i2c_link_monitor #(
    parameter int unsigned TIMEOUT_CYCLES = 2000
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic m_sda_out,
    input wire logic m_sda_oe,
    input wire logic t_sda_out,
    input wire logic t_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////
    // Time since scl last moved; a held sda must not outlive it
    logic scl_q;
    logic [31:0] still;
    always_ff @(posedge sys_clk) begin
        scl_q <= scl;
        still <= (sys_rst || scl != scl_q) ? 32'h0 : still + 32'h1;
    end
    sequence s_high; scl [*8]; endsequence
    sequence s_low; !scl [*8]; endsequence
    sequence s_quiet; $stable(t_sda_oe) [*3]; endsequence
    property p_released; $fell(sys_rst) |-> !(scl_oe || m_sda_oe || t_sda_oe); endproperty
    property p_scl_high; $rose(scl) |-> s_high; endproperty
    property p_scl_low; $fell(scl) |-> s_low; endproperty
    property p_lag; $rose(t_sda_oe) |-> !scl && !$past(scl, 3); endproperty
    property p_hold; $fell(scl) |-> s_quiet; endproperty
    // Both pulling low is harmless in the low-phase handover, never while scl is high
    property p_no_fight; t_sda_oe && m_sda_oe |-> !scl; endproperty
    property p_timeout; t_sda_oe |-> still < TIMEOUT_CYCLES + 32; endproperty
    property p_start; $fell(sda) && scl |-> m_sda_oe && !t_sda_oe; endproperty
    a_released: assert property (p_released) else $error("line held after reset");
    a_scl_high: assert property (p_scl_high) else $error("scl high too short");
    a_scl_low: assert property (p_scl_low) else $error("scl low too short");
    a_lag: assert property (p_lag) else $error("target drove sda early");
    a_hold: assert property (p_hold) else $error("target moved sda at fall");
    a_no_fight: assert property (p_no_fight) else $error("both drive sda");
    a_timeout: assert property (p_timeout) else $error("sda held on idle scl");
    a_start: assert property (p_start) else $error("start not by master");
endmodule

// >>> testbench/i2c_config_register_port_bench.sv
/* Bench: master and target joined over one link, driven from the
   master's user side. Assumes one sys_clk; the master makes scl. */
`timescale 1ns/100ps
module i2c_config_register_port_bench;
    logic sys_clk = 1'b0;
    logic sys_rst, cmd_valid, cmd_write, fast_mode, addr_sel, busy, byte_done, done;
    logic nack_err, wr_strobe, low_volt_mode;
    logic [6:0] cmd_target;
    logic [7:0] cmd_reg, cmd_count, wr_data, rd_data, user_addr, user_data, wr_addr, tgt_data;
    logic [7:0] mem [256];
    logic [31:0] seed = 32'h0000003B;
    logic m_rst = 1'b0;
    int errors = 0;
    int checks_done = 0;
    int strobes = 0;
    int stored = 0;
    int cycles = 0;
    i2c_link_if link ();
    i2c_config_master i2c_config_master_inst (.sys_clk(sys_clk), .sys_rst(sys_rst | m_rst),
        .link(link), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .fast_mode(fast_mode),
        .cmd_target(cmd_target), .cmd_reg(cmd_reg), .cmd_count(cmd_count), .wr_data(wr_data),
        .busy(busy), .byte_done(byte_done), .rd_data(rd_data), .done(done), .nack_err(nack_err));
    i2c_config_target #(.HAS_ADDR_SEL(1'b1), .TIMEOUT_CYCLES(2000)) i2c_config_target_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .link(link), .addr_sel(addr_sel),
        .user_addr(user_addr), .user_data(user_data), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
        .wr_data(tgt_data), .low_volt_mode(low_volt_mode));
    i2c_link_monitor #(.TIMEOUT_CYCLES(2000)) i2c_link_monitor_inst (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .scl_out(link.scl_out), .scl_oe(link.scl_oe),
        .m_sda_out(link.m_sda_out), .m_sda_oe(link.m_sda_oe), .t_sda_out(link.t_sda_out),
        .t_sda_oe(link.t_sda_oe), .scl(link.scl), .sda(link.sda));
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    function automatic logic [6:0] own(input logic sel);
        return {i2c_cfg_pkg::ADDR_FIXED_HI, sel};
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expd);
        checks_done++;
        if (seen !== expd) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, expd, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Entered at a falling edge; the model only learns bytes the target accepts
    task automatic run(input logic wr, input logic fm, input logic [6:0] tgt,
                       input logic [7:0] rg, input logic [7:0] cnt, input logic [7:0] d0);
        logic [7:0] a;
        a = rg;
        {cmd_write, fast_mode, cmd_target, cmd_reg, cmd_count, wr_data} = {wr, fm, tgt, rg, cnt, d0};
        cmd_valid = 1'b1;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        check("busy", {7'h00, busy}, 8'h01);
        while (done !== 1'b1) begin
            @(negedge sys_clk);
            if (byte_done === 1'b1 && !wr) begin
                check("rd_data", rd_data, mem[a]);
            end
            if (byte_done === 1'b1 && wr && tgt == own(addr_sel)) begin
                mem[a] = wr_data;
                stored++;
            end
            if (byte_done === 1'b1) begin
                wr_data = rnd();
                a++;
            end
        end
        check("nack_err", {7'h00, nack_err}, {7'h00, tgt != own(addr_sel)});
        @(negedge sys_clk);
        check("strobes", strobes[7:0], stored[7:0]);
    endtask
    task automatic readback(input logic [7:0] base, input int cnt);
        for (int i = 0; i < cnt; i++) begin
            user_addr = base + i[7:0];
            @(negedge sys_clk);
            check("user_data", user_data, mem[user_addr]);
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // Ceiling sits well above the longest expected run
    always @(posedge sys_clk) begin
        cycles++;
        if (wr_strobe === 1'b1) begin
            strobes++;
        end
        if (cycles == 95000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'h00;
        end
        sys_rst = 1'b1;
        addr_sel = 1'b1;
        {cmd_valid, cmd_write, fast_mode, cmd_target, cmd_reg, cmd_count, wr_data} = 34'h0;
        user_addr = 8'h00;
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (8) @(negedge sys_clk);
        // Burst across the top of the space to catch pointer wrap
        run(1'b1, 1'b1, own(1'b1), 8'hFE, 8'h03, rnd());
        readback(8'hFE, 3);
        check("wr_addr", wr_addr, 8'h00);
        check("wr_data", tgt_data, mem[8'h00]);
        run(1'b0, 1'b1, own(1'b1), 8'hFE, 8'h03, 8'h00);
        run(1'b1, 1'b0, own(1'b1), i2c_cfg_pkg::LOWV_REG, 8'h01, 8'h80 | rnd());
        check("low_volt_mode", {7'h00, low_volt_mode}, 8'h01);
        for (int s = 1; s >= 0; s--) begin
            addr_sel = s[0];
            repeat (4) @(negedge sys_clk);
            run(1'b1, 1'b1, own(~s[0]), 8'h40, 8'h01, rnd());
            run(1'b1, 1'b1, own(s[0]), 8'h40, 8'h01, rnd());
            readback(8'h40, 1);
        end
        // Master dropped during the address ack: the target must let go by itself
        {cmd_valid, cmd_write, cmd_target} = {1'b1, 1'b1, own(addr_sel)};
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        while (link.t_sda_oe !== 1'b1) begin
            @(negedge sys_clk);
        end
        m_rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        m_rst = 1'b0;
        repeat (1900) @(negedge sys_clk);
        check("t_sda_oe", {7'h00, link.t_sda_oe}, 8'h01);
        repeat (200) @(negedge sys_clk);
        check("t_sda_oe", {7'h00, link.t_sda_oe}, 8'h00);
        tally_and_finish();
    end
endmodule
